/* File: bench/dmd_host.sv */
/*
 Host model: drives command bytes onto the decoder's command port.
 Assumes its tasks are called just after a rising clk edge.
*/
`timescale 1ns/100ps
module dmd_host
  import dmd_pkg::*;
(
  output logic cmd_valid,
  output logic [CMD_W-1:0] cmd_code
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end
  // One byte per strobe, no parameters
  task automatic issue(input logic [CMD_W-1:0] code);
    cmd_valid <= 1'b1;
    cmd_code <= code;
  endtask : issue
  // Idle code is inverted, never stale
  task automatic stop;
    cmd_valid <= 1'b0;
    cmd_code <= ~cmd_code;
  endtask : stop
endmodule : dmd_host

/* File: bench/tb_top.sv */
/*
 Testbench for the display mode command decoder.
 Assumes the host model in dmd_host.sv and a 125 MHz clock.
*/
`timescale 1ns/100ps
module tb_top
  import dmd_pkg::*;
;
  logic clk, reset_n, soft_reset, cmd_valid, pm, nm, inv, mc;
  logic [CMD_W-1:0] cmd_code;
  logic [ROW_W-1:0] ar_s, ar_e, sc_s, sc_e;
  int n_mismatch = 0;
  int compares = 0;
  dmd_host host (.cmd_valid(cmd_valid), .cmd_code(cmd_code));
  dmd_decoder dut_u (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .area_row_start(ar_s),
    .area_row_end(ar_e), .partial_mode(pm), .normal_mode(nm), .inversion_on(inv),
    .scan_row_start(sc_s), .scan_row_end(sc_e), .mode_changed(mc));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic p, input logic i, input logic c);
    logic [35:0] e;
    e = {p, ~p, i, c, p ? ar_s : FULL_ROW_START, p ? ar_e : FULL_ROW_END};
    compares++;
    if ({pm, nm, inv, mc, sc_s, sc_e} !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, {pm, nm, inv, mc, sc_s, sc_e}, e);
    end
  endtask : chk
  task automatic op(input logic [CMD_W-1:0] code, input logic p, i, c);
    @(posedge clk);
    host.issue(code);
    @(posedge clk);
    host.stop();
    #1 chk(p, i, c);
  endtask : op
  task automatic t_mode;
    op(CMD_PARTIAL_ON, 1'b1, 1'b0, 1'b1);
    op(CMD_PARTIAL_ON, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    ar_s <= 16'h0010;
    ar_e <= 16'h0100;
    repeat (2) @(posedge clk);
    #1 chk(1'b1, 1'b0, 1'b0);
    op(CMD_INVERSION_ENABLE, 1'b1, 1'b1, 1'b1);
    op(CMD_INVERSION_DISABLE, 1'b1, 1'b0, 1'b1);
    op(CMD_NORMAL_ON, 1'b0, 1'b0, 1'b1);
    op(CMD_NORMAL_ON, 1'b0, 1'b0, 1'b0);
    op(CMD_PARTIAL_AREA, 1'b0, 1'b0, 1'b0);
  endtask : t_mode
  task automatic t_invert;
    op(CMD_INVERSION_ENABLE, 1'b0, 1'b1, 1'b1);
    op(CMD_INVERSION_ENABLE, 1'b0, 1'b1, 1'b0);
    op(CMD_INVERSION_DISABLE, 1'b0, 1'b0, 1'b1);
    op(CMD_INVERSION_DISABLE, 1'b0, 1'b0, 1'b0);
  endtask : t_invert
  task automatic t_burst;
    @(posedge clk);
    host.issue(CMD_PARTIAL_ON);
    @(posedge clk);
    host.issue(CMD_INVERSION_ENABLE);
    #1 chk(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    soft_reset <= 1'b1;
    #1 chk(1'b1, 1'b1, 1'b1);
    @(posedge clk);
    host.stop();
    soft_reset <= 1'b0;
    #1 chk(1'b0, 1'b0, 1'b0);
    op(CMD_PARTIAL_ON, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    reset_n <= 1'b0;
    #1 chk(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk(1'b0, 1'b0, 1'b0);
  endtask : t_burst
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    reset_n = 1'b0;
    soft_reset = 1'b0;
    ar_s = 16'h0040;
    ar_e = 16'h00bf;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk(1'b0, 1'b0, 1'b0);
    t_mode();
    t_invert();
    t_burst();
    t_invert();
    report_and_stop();
  end
  initial begin
    #5000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top

/* File: hw/dmd_decoder.sv */
/*
 Display mode command decoder: partial/normal mode and display inversion flags,
 plus the row window that the panel scan logic should use.
 Assumes cmd_valid and cmd_code come from the command interface on clk, and that
 the partial-area rows come from the partial-area command handler on clk.
*/
// Notes on behaviour
// - Command 12h sets partial mode and leaves normal mode.
// - In partial mode, displayed rows come from the partial-area command 30h.
// - Command 12h while already partial changes nothing.
// - Command 13h enters normal mode; normal_mode comes from its own flop, normal_reg, kept opposite to the mode flag.
// - Normal mode is left only by command 12h.
// - Command 13h while already normal changes nothing.
// - Command 20h clears the inversion flag.
// - Command 20h with inversion already off changes nothing.
// - Command 21h sets the inversion flag.
// - Command 21h with inversion already on changes nothing.
`timescale 1ns/100ps
module dmd_decoder
  import dmd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] cmd_code,
  input wire logic [ROW_W-1:0] area_row_start,
  input wire logic [ROW_W-1:0] area_row_end,
  output logic partial_mode,
  output logic normal_mode,
  output logic inversion_on,
  output logic [ROW_W-1:0] scan_row_start,
  output logic [ROW_W-1:0] scan_row_end,
  output logic mode_changed
);

  dmd_mode_e mode_reg;
  dmd_mode_e mode_next;
  logic invert_reg;
  logic invert_next;
  logic [ROW_W-1:0] row_start_reg;
  logic [ROW_W-1:0] row_start_next;
  logic [ROW_W-1:0] row_end_reg;
  logic [ROW_W-1:0] row_end_next;
  logic changed_reg;
  logic normal_reg;

  // Command decode; no sleep or idle gating
  wire hit_partial = cmd_valid && (cmd_code == CMD_PARTIAL_ON);
  wire hit_normal = cmd_valid && (cmd_code == CMD_NORMAL_ON);
  wire hit_inv_off = cmd_valid && (cmd_code == CMD_INVERSION_DISABLE);
  wire hit_inv_on = cmd_valid && (cmd_code == CMD_INVERSION_ENABLE);

  // Single flag for both modes
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      DMD_NORMAL: begin
        if (hit_partial) begin
          mode_next = DMD_PARTIAL;
        end
      end
      DMD_PARTIAL: begin
        if (hit_normal) begin
          mode_next = DMD_NORMAL;
        end
      end
      default: begin
        mode_next = DMD_NORMAL;
      end
    endcase
  end

  // Repeats leave the flag as is
  assign invert_next = hit_inv_on ? 1'b1 : (hit_inv_off ? 1'b0 : invert_reg);

  // Window follows partial area only in partial mode
  assign row_start_next = (mode_next == DMD_PARTIAL) ? area_row_start : FULL_ROW_START;
  assign row_end_next = (mode_next == DMD_PARTIAL) ? area_row_end : FULL_ROW_END;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= DMD_NORMAL;
      normal_reg <= RST_NORMAL;
      invert_reg <= RST_INVERT;
      row_start_reg <= RST_ROW_START;
      row_end_reg <= RST_ROW_END;
      changed_reg <= 1'b0;
    end else if (soft_reset) begin
      mode_reg <= DMD_NORMAL;
      normal_reg <= RST_NORMAL;
      invert_reg <= RST_INVERT;
      row_start_reg <= RST_ROW_START;
      row_end_reg <= RST_ROW_END;
      changed_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      normal_reg <= (mode_next == DMD_NORMAL);
      invert_reg <= invert_next;
      row_start_reg <= row_start_next;
      row_end_reg <= row_end_next;
      changed_reg <= (mode_next != mode_reg) || (invert_next != invert_reg);
    end
  end

  // Outputs straight from flops
  assign partial_mode = (mode_reg == DMD_PARTIAL);
  assign normal_mode = normal_reg;
  assign inversion_on = invert_reg;
  assign scan_row_start = row_start_reg;
  assign scan_row_end = row_end_reg;
  assign mode_changed = changed_reg;

  // Checks
  a_partial_set: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_partial && !soft_reset)
    |=> partial_mode && !normal_mode)
    else $error("partial on did not set partial mode");

  a_normal_set: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_normal && !soft_reset)
    |=> normal_mode && !partial_mode)
    else $error("normal on did not set normal mode");

  a_partial_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (partial_mode && !hit_normal && !soft_reset)
    |=> partial_mode)
    else $error("partial mode left without normal command");

  a_normal_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (normal_mode && !hit_partial)
    |=> normal_mode)
    else $error("normal mode left without partial command");

  a_partial_repeat: assert property (@(posedge clk) disable iff (!reset_n)
    (partial_mode && hit_partial && !soft_reset)
    |=> !mode_changed && partial_mode)
    else $error("repeated partial on changed state");

  a_normal_repeat: assert property (@(posedge clk) disable iff (!reset_n)
    (normal_mode && hit_normal && !soft_reset)
    |=> !mode_changed && normal_mode)
    else $error("repeated normal on changed state");

  a_inv_off: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_inv_off && !soft_reset)
    |=> !inversion_on)
    else $error("inversion off not applied");

  a_inv_on: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_inv_on && !soft_reset)
    |=> inversion_on)
    else $error("inversion on not applied");

  a_inv_stable: assert property (@(posedge clk) disable iff (!reset_n)
    (!hit_inv_on && !hit_inv_off && !soft_reset)
    |=> $stable(inversion_on))
    else $error("inversion changed without command");

  a_soft_reset: assert property (@(posedge clk) disable iff (!reset_n)
    soft_reset
    |=> normal_mode && !inversion_on && !mode_changed)
    else $error("soft reset did not restore defaults");

  a_window_src: assert property (@(posedge clk) disable iff (!reset_n)
    (partial_mode && !soft_reset && !hit_normal)
    |=> scan_row_end == $past(area_row_end))
    else $error("partial window not taken from partial area");

  a_inv_off_repeat: assert property (@(posedge clk) disable iff (!reset_n)
    (!inversion_on && hit_inv_off && !soft_reset)
    |=> !inversion_on && !mode_changed)
    else $error("repeated inversion off changed state");

  a_inv_on_repeat: assert property (@(posedge clk) disable iff (!reset_n)
    (inversion_on && hit_inv_on && !soft_reset)
    |=> inversion_on && !mode_changed)
    else $error("repeated inversion on changed state");

  a_mode_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
    partial_mode
    != normal_mode)
    else $error("partial and normal mode not exclusive");

  a_enter_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    (normal_mode && hit_partial && !soft_reset)
    |=> mode_changed)
    else $error("entering partial mode gave no change pulse");

  a_leave_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    (partial_mode && hit_normal && !soft_reset)
    |=> mode_changed)
    else $error("leaving partial mode gave no change pulse");

  a_inv_on_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    (!inversion_on && hit_inv_on && !soft_reset)
    |=> mode_changed)
    else $error("inversion on gave no change pulse");

  a_inv_off_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    (inversion_on && hit_inv_off && !soft_reset)
    |=> mode_changed)
    else $error("inversion off gave no change pulse");

  a_pulse_no_soft: assert property (@(posedge clk) disable iff (!reset_n)
    mode_changed
    |-> !$past(soft_reset))
    else $error("change pulse after soft reset");

  a_changed_needs_cmd: assert property (@(posedge clk) disable iff (!reset_n)
    mode_changed
    |-> $past(hit_partial || hit_normal || hit_inv_on || hit_inv_off))
    else $error("change pulse without a mode command");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (!cmd_valid && !soft_reset)
    |=> !mode_changed && $stable(partial_mode) && $stable(inversion_on))
    else $error("state changed with no command");

  a_other_code: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_valid && (cmd_code == CMD_PARTIAL_AREA) && !soft_reset)
    |=> !mode_changed && $stable(partial_mode) && $stable(inversion_on))
    else $error("partial area code changed mode state");

  a_normal_window: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_normal && !soft_reset)
    |=> scan_row_start == FULL_ROW_START && scan_row_end == FULL_ROW_END)
    else $error("normal mode window not full");

  a_window_start: assert property (@(posedge clk) disable iff (!reset_n)
    (partial_mode && !soft_reset && !hit_normal)
    |=> scan_row_start == $past(area_row_start))
    else $error("partial window start not taken from partial area");

  a_enter_window: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_partial && !soft_reset)
    |=> scan_row_start == $past(area_row_start) && scan_row_end == $past(area_row_end))
    else $error("window not taken on entering partial mode");

  a_normal_full: assert property (@(posedge clk) disable iff (!reset_n)
    normal_mode
    |-> scan_row_start == FULL_ROW_START && scan_row_end == FULL_ROW_END)
    else $error("normal mode shows a partial window");

  a_soft_window: assert property (@(posedge clk) disable iff (!reset_n)
    soft_reset
    |=> scan_row_start == RST_ROW_START && scan_row_end == RST_ROW_END)
    else $error("soft reset did not restore window");

  a_soft_beats_mode: assert property (@(posedge clk) disable iff (!reset_n)
    (soft_reset && hit_partial)
    |=> !partial_mode)
    else $error("command won over soft reset");

  a_soft_beats_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (soft_reset && hit_inv_on)
    |=> !inversion_on)
    else $error("inversion won over soft reset");

  a_inv_keeps_mode: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_inv_on && !soft_reset)
    |=> $stable(partial_mode))
    else $error("inversion command changed mode");

  a_mode_keeps_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_partial && !soft_reset)
    |=> $stable(inversion_on))
    else $error("partial command changed inversion");

  a_partial_inverted: assert property (@(posedge clk) disable iff (!reset_n)
    (inversion_on && hit_partial && !soft_reset)
    |=> partial_mode && inversion_on)
    else $error("partial on refused while inverted");

  a_normal_inverted: assert property (@(posedge clk) disable iff (!reset_n)
    (inversion_on && hit_normal && !soft_reset)
    |=> normal_mode && inversion_on)
    else $error("normal on refused while inverted");

  a_normal_keeps_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (hit_normal && !soft_reset)
    |=> $stable(inversion_on))
    else $error("normal command changed inversion");

  a_mode_stable: assert property (@(posedge clk) disable iff (!reset_n)
    (!hit_partial && !hit_normal && !soft_reset)
    |=> $stable(partial_mode))
    else $error("mode changed without mode command");

  c_enter_partial: cover property (@(posedge clk) disable iff (!reset_n)
    normal_mode ##1 partial_mode);

  c_leave_partial: cover property (@(posedge clk) disable iff (!reset_n)
    partial_mode ##1 normal_mode);

  c_invert_toggle: cover property (@(posedge clk) disable iff (!reset_n)
    inversion_on ##1 !inversion_on);

  c_repeat_inv_on: cover property (@(posedge clk) disable iff (!reset_n)
    inversion_on && hit_inv_on);

  c_repeat_partial: cover property (@(posedge clk) disable iff (!reset_n)
    partial_mode && hit_partial);

endmodule : dmd_decoder

/* File: hw/dmd_pkg.sv */
/*
 Package for the display mode command decoder: command codes, widths and reset values.
 Assumes the system interface delivers one command byte per strobe on the block clock.
*/
package dmd_pkg;
  localparam int CMD_W = 8;
  localparam int ROW_W = 16;
  localparam logic [CMD_W-1:0] CMD_PARTIAL_ON = 8'h12;
  localparam logic [CMD_W-1:0] CMD_NORMAL_ON = 8'h13;
  localparam logic [CMD_W-1:0] CMD_INVERSION_DISABLE = 8'h20;
  localparam logic [CMD_W-1:0] CMD_INVERSION_ENABLE = 8'h21;
  localparam logic [CMD_W-1:0] CMD_PARTIAL_AREA = 8'h30;
  localparam logic RST_PARTIAL = 1'b0;
  localparam logic RST_INVERT = 1'b0;
  localparam logic RST_NORMAL = 1'b1;
  localparam logic [ROW_W-1:0] RST_ROW_START = 16'h0000;
  localparam logic [ROW_W-1:0] RST_ROW_END = 16'h013f;
  localparam logic [ROW_W-1:0] FULL_ROW_START = 16'h0000;
  localparam logic [ROW_W-1:0] FULL_ROW_END = 16'h013f;
  // Mode state, Gray coded
  typedef enum logic [0:0] {
    DMD_NORMAL = 1'b0,
    DMD_PARTIAL = 1'b1
  } dmd_mode_e;
endpackage : dmd_pkg
